/* ocr_regs.sv */
// ocr_regs: ahb-lite output configuration register bank with offset hold loop
//
// Summary of operation
// - Writing one to reg 0x00 bit 1 restores all defaults; bit self-clears.
// - Reg 0x00 bit 0 high: readout off, output pin actively driven low.
// - Reg 0x00 bit 0 low: output pin shifts out data on reads.
// - Reg 0x10 bits 7:6 pick clock buffer drive strength.
// - Reg 0x11 bits 1:0 pick data buffer drive strength, same codes.
// - Reg 0x11 bits 5:4 code 01 doubles clock buffer current only.
// - Doubling code 10 doubles data and clock; code 11 undefined.
// - Reg 0x12 bits 5:3 pick data output termination, 000 none.
// - Reg 0x12 bits 2:0 pick clock output termination, same codes.
// - Reg 0x13 bit 4 high freezes offset estimate, still subtracted.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ocr_regs #(
  parameter int SAMPLE_W  = 11,                 // converter sample width
  parameter int OFS_SHIFT = 8                   // offset loop time constant
) (
  input  wire logic                          core_clk_in,      // core clock
  input  wire logic                          sys_rst_in,       // sync reset, high
  input  wire logic                          hsel_in,          // ahb slave select
  input  wire logic [31:0]                   haddr_in,         // ahb address
  input  wire logic [1:0]                    htrans_in,        // ahb transfer type
  input  wire logic                          hwrite_in,        // ahb write
  input  wire logic [2:0]                    hsize_in,         // ahb size, word only
  input  wire logic [ocr_pkg::OCR_BUS_W-1:0] hwdata_in,        // ahb write data
  input  wire logic                          hready_in,        // ahb bus ready
  output logic                               hreadyout_out,    // ahb slave ready
  output logic [ocr_pkg::OCR_BUS_W-1:0]      hrdata_out,       // ahb read data
  output logic                               hresp_out,        // ahb response
  input  wire logic                          sample_valid_in,  // sample strobe
  input  wire logic [SAMPLE_W-1:0]           sample_in,        // signed sample
  output logic [SAMPLE_W:0]                  corrected_out,    // offset removed
  output logic                               corrected_vld_out, // result strobe
  output logic                               serial_out_pin_out, // readout pin level
  output logic                               serial_out_pin_oe_out, // pin enable
  output logic [1:0]                         clk_drive_out,    // clock buffer strength
  output logic [1:0]                         data_drive_out,   // data buffer strength
  output logic [1:0]                         lvds_current_out, // current level code
  output logic                               clk_double_out,   // clock current x2
  output logic                               data_double_out,  // data current x2
  output logic [2:0]                         data_term_out,    // data termination
  output logic [2:0]                         clk_term_out,     // clock termination
  output logic                               offset_frozen_out // loop on hold
);
  import ocr_pkg::*;

  localparam int ACC_W = SAMPLE_W + OFS_SHIFT;

  // index compare on the word address bits
  function automatic logic idx_hit(input logic [7:0] idx, input logic [31:0] addr);
    idx_hit = (addr[OCR_IDX_LSB +: OCR_REG_W] == idx) &&
              (addr[31:OCR_IDX_LSB+OCR_REG_W] == '0) &&
              (addr[OCR_IDX_LSB-1:0] == '0);
  endfunction

  // ---------------------------------------------------------------
  // ahb address phase capture
  // ---------------------------------------------------------------
  logic        wr_pend_r, wr_pend_nxt;
  logic [31:0] wr_addr_r, wr_addr_nxt;
  logic        addr_act;
  logic        rd_take;

  // a transfer is taken when selected, active and the bus is ready
  assign addr_act = hsel_in && htrans_in[OCR_HTRANS_ACT_BIT] && hready_in;
  assign rd_take  = addr_act && !hwrite_in;

  always_comb begin
    wr_pend_nxt = addr_act && hwrite_in;
    wr_addr_nxt = addr_act ? haddr_in : wr_addr_r;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] rdo_r, rdo_nxt;           // readout control
  logic [7:0] clkdrv_r, clkdrv_nxt;     // clock output drive
  logic [7:0] curdrv_r, curdrv_nxt;     // current and data drive
  logic [7:0] term_r, term_nxt;         // termination select
  logic [7:0] hold_r, hold_nxt;         // offset hold control
  logic       swrst_r, swrst_nxt;       // one-cycle software reset pulse
  logic [7:0] wbyte;

  assign wbyte = hwdata_in[OCR_REG_W-1:0];

  // write in the data phase; every field of a word lands at once
  always_comb begin
    rdo_nxt    = rdo_r;
    clkdrv_nxt = clkdrv_r;
    curdrv_nxt = curdrv_r;
    term_nxt   = term_r;
    hold_nxt   = hold_r;
    swrst_nxt  = 1'b0;
    if (wr_pend_r) begin
      // fixed-zero bits are masked off so they always read zero
      if (idx_hit(OCR_IDX_RST_READOUT, wr_addr_r)) begin
        rdo_nxt   = wbyte & OCR_MASK_RST_READOUT;
        swrst_nxt = wbyte[OCR_SWRST_BIT];
      end else if (idx_hit(OCR_IDX_CLK_DRIVE, wr_addr_r)) begin
        clkdrv_nxt = wbyte & OCR_MASK_CLK_DRIVE;
      end else if (idx_hit(OCR_IDX_CUR_DRIVE, wr_addr_r)) begin
        curdrv_nxt = wbyte & OCR_MASK_CUR_DRIVE;
      end else if (idx_hit(OCR_IDX_TERM, wr_addr_r)) begin
        term_nxt = wbyte & OCR_MASK_TERM;
      end else if (idx_hit(OCR_IDX_OFS_HOLD, wr_addr_r)) begin
        hold_nxt = wbyte & OCR_MASK_OFS_HOLD;
      end
    end
    // software reset wins over the rest of the same write
    if (swrst_nxt) begin
      rdo_nxt    = OCR_RST_VAL;
      clkdrv_nxt = OCR_RST_VAL;
      curdrv_nxt = OCR_RST_VAL;
      term_nxt   = OCR_RST_VAL;
      hold_nxt   = OCR_RST_VAL;
    end
  end

  // the reset bit itself is never stored, only pulsed for a cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdo_r    <= OCR_RST_VAL;
      clkdrv_r <= OCR_RST_VAL;
      curdrv_r <= OCR_RST_VAL;
      term_r   <= OCR_RST_VAL;
      hold_r   <= OCR_RST_VAL;
      swrst_r  <= 1'b0;
    end else begin
      rdo_r    <= rdo_nxt;
      clkdrv_r <= clkdrv_nxt;
      curdrv_r <= curdrv_nxt;
      term_r   <= term_nxt;
      hold_r   <= hold_nxt;
      swrst_r  <= swrst_nxt;
    end
  end

  // ---------------------------------------------------------------
  // decoded buffer controls, registered so outputs come from flops
  // ---------------------------------------------------------------
  logic [1:0] dbl_code;
  logic       clk_dbl_nxt, data_dbl_nxt;

  assign dbl_code = curdrv_nxt[OCR_DOUBLE_LSB +: 2];

  // code 11 is undefined; it is stored but treated like no doubling
  always_comb begin
    clk_dbl_nxt  = 1'b0;
    data_dbl_nxt = 1'b0;
    case (dbl_code)
      OCR_DBL_CLK: begin
        clk_dbl_nxt = 1'b1;
      end
      OCR_DBL_BOTH: begin
        clk_dbl_nxt  = 1'b1;
        data_dbl_nxt = 1'b1;
      end
      default: begin
        clk_dbl_nxt  = 1'b0;
        data_dbl_nxt = 1'b0;
      end
    endcase
  end

  // drive, current and termination codes pass straight to the pads
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_drive_out     <= OCR_DRV_DEFAULT;
      data_drive_out    <= OCR_DRV_DEFAULT;
      lvds_current_out  <= '0;
      clk_double_out    <= 1'b0;
      data_double_out   <= 1'b0;
      data_term_out     <= '0;
      clk_term_out      <= '0;
      offset_frozen_out <= 1'b0;
    end else begin
      clk_drive_out     <= clkdrv_nxt[OCR_CLKDRV_LSB +: 2];
      data_drive_out    <= curdrv_nxt[OCR_DATDRV_LSB +: 2];
      lvds_current_out  <= curdrv_nxt[OCR_CURRENT_LSB +: 2];
      clk_double_out    <= clk_dbl_nxt;
      data_double_out   <= data_dbl_nxt;
      data_term_out     <= term_nxt[OCR_DATTERM_LSB +: 3];
      clk_term_out      <= term_nxt[OCR_CLKTERM_LSB +: 3];
      offset_frozen_out <= hold_nxt[OCR_FREEZE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // offset correction loop
  // ---------------------------------------------------------------
  logic signed [ACC_W-1:0]  est_acc_r, est_acc_nxt;
  logic signed [ACC_W-1:0]  sample_ext;
  logic signed [SAMPLE_W-1:0] estimate;
  logic [SAMPLE_W:0]        corr_nxt;
  logic                     freeze;

  assign freeze     = hold_r[OCR_FREEZE_BIT];
  assign sample_ext = {{OFS_SHIFT{sample_in[SAMPLE_W-1]}}, sample_in};
  assign estimate   = est_acc_r[ACC_W-1:OFS_SHIFT];

  // leaky average of the samples; the divide by shift keeps it multiplier free
  always_comb begin
    est_acc_nxt = est_acc_r;
    if (swrst_r) begin
      est_acc_nxt = '0;
    end else if (sample_valid_in && !freeze) begin
      est_acc_nxt = est_acc_r + sample_ext - (est_acc_r >>> OFS_SHIFT);
    end
    // on hold the last estimate is still subtracted
    corr_nxt = {sample_in[SAMPLE_W-1], sample_in} - {estimate[SAMPLE_W-1], estimate};
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      est_acc_r         <= '0;
      corrected_out     <= '0;
      corrected_vld_out <= 1'b0;
    end else begin
      est_acc_r         <= est_acc_nxt;
      corrected_out     <= sample_valid_in ? corr_nxt : corrected_out;
      corrected_vld_out <= sample_valid_in;
    end
  end

  // ---------------------------------------------------------------
  // read path and bus answer
  // ---------------------------------------------------------------
  logic [7:0]           rd_byte;
  logic [7:0]           status_byte;
  logic [OCR_BUS_W-1:0] hrdata_nxt;
  logic                 sh_busy;

  // status shows shifter activity and the reset pulse
  always_comb begin
    status_byte                   = '0;
    status_byte[OCR_BUSY_BIT]     = sh_busy;
    status_byte[OCR_SWRST_ST_BIT] = swrst_r;
  end

  // read uses next values so a write just before a read is seen
  always_comb begin
    rd_byte = '0;
    if (idx_hit(OCR_IDX_RST_READOUT, haddr_in)) begin
      rd_byte = rdo_nxt;                          // reset bit reads zero
    end else if (idx_hit(OCR_IDX_STATUS, haddr_in)) begin
      rd_byte = status_byte;
    end else if (idx_hit(OCR_IDX_CLK_DRIVE, haddr_in)) begin
      rd_byte = clkdrv_nxt;
    end else if (idx_hit(OCR_IDX_CUR_DRIVE, haddr_in)) begin
      rd_byte = curdrv_nxt;
    end else if (idx_hit(OCR_IDX_TERM, haddr_in)) begin
      rd_byte = term_nxt;
    end else if (idx_hit(OCR_IDX_OFS_HOLD, haddr_in)) begin
      rd_byte = hold_nxt;
    end
    hrdata_nxt = rd_take ? {{(OCR_BUS_W-OCR_REG_W){1'b0}}, rd_byte} : '0;
  end

  // zero wait state slave; unmapped reads give zero, always okay
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      hreadyout_out <= 1'b1;
      hrdata_out    <= '0;
      hresp_out     <= OCR_HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hrdata_out    <= hrdata_nxt;
      hresp_out     <= OCR_HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // serial readout pin
  // ---------------------------------------------------------------
  // an accepted read also leaves on the pin when readout is enabled and the shifter is idle; reads while it is busy are dropped
  ocr_serial_shift #(
    .BYTE_W      (OCR_REG_W)
  ) u_shift (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .disable_in  (rdo_r[OCR_READOUT_BIT]),
    .start_in    (rd_take),
    .byte_in     (rd_byte),
    .pin_out     (serial_out_pin_out),
    .pin_oe_out  (serial_out_pin_oe_out),
    .busy_out    (sh_busy)
  );

endmodule

/* ocr_pkg.sv */
// ocr_pkg: register map, field layout and reset values of the output config registers
package ocr_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] OCR_IDX_RST_READOUT = 8'h00;
  localparam logic [7:0] OCR_IDX_STATUS      = 8'h01;
  localparam logic [7:0] OCR_IDX_CLK_DRIVE   = 8'h10;
  localparam logic [7:0] OCR_IDX_CUR_DRIVE   = 8'h11;
  localparam logic [7:0] OCR_IDX_TERM        = 8'h12;
  localparam logic [7:0] OCR_IDX_OFS_HOLD    = 8'h13;

  // register width and word address bit positions
  localparam int OCR_REG_W    = 8;
  localparam int OCR_BUS_W    = 32;
  localparam int OCR_IDX_LSB  = 2;

  // field positions
  localparam int OCR_READOUT_BIT  = 0;
  localparam int OCR_SWRST_BIT    = 1;
  localparam int OCR_CLKDRV_LSB   = 6;
  localparam int OCR_DATDRV_LSB   = 0;
  localparam int OCR_CURRENT_LSB  = 2;
  localparam int OCR_DOUBLE_LSB   = 4;
  localparam int OCR_CLKTERM_LSB  = 0;
  localparam int OCR_DATTERM_LSB  = 3;
  localparam int OCR_FREEZE_BIT   = 4;
  localparam int OCR_BUSY_BIT     = 0;
  localparam int OCR_SWRST_ST_BIT = 1;

  // writable bit masks; fixed-zero positions are dropped on write
  localparam logic [7:0] OCR_MASK_RST_READOUT = 8'h01;
  localparam logic [7:0] OCR_MASK_CLK_DRIVE   = 8'hc0;
  localparam logic [7:0] OCR_MASK_CUR_DRIVE   = 8'h3f;
  localparam logic [7:0] OCR_MASK_TERM        = 8'h3f;
  localparam logic [7:0] OCR_MASK_OFS_HOLD    = 8'h10;

  // defaults after power-on or software reset
  localparam logic [7:0] OCR_RST_VAL = 8'h00;

  // drive strength codes
  localparam logic [1:0] OCR_DRV_DEFAULT  = 2'h0;
  localparam logic [1:0] OCR_DRV_WEAKER   = 2'h1;
  localparam logic [1:0] OCR_DRV_MAXIMUM  = 2'h2;
  localparam logic [1:0] OCR_DRV_STRONGER = 2'h3;

  // current doubling codes
  localparam logic [1:0] OCR_DBL_NONE     = 2'h0;
  localparam logic [1:0] OCR_DBL_CLK      = 2'h1;
  localparam logic [1:0] OCR_DBL_BOTH     = 2'h2;

  // ahb transfer type msb marks nonseq or seq
  localparam int OCR_HTRANS_ACT_BIT = 1;
  localparam logic OCR_HRESP_OKAY   = 1'b0;

  // serial shifter states
  typedef enum logic [1:0] {OCR_SH_IDLE, OCR_SH_SHIFT} ocr_sh_state_t;

endpackage

/* ocr_serial_shift.sv */
// ocr_serial_shift: serial readout pin driver, shifts a read byte out msb first
`timescale 1ns/1ps
module ocr_serial_shift #(
  parameter int BYTE_W = 8                 // bits per readout
) (
  input  wire logic              core_clk_in,   // core clock
  input  wire logic              sys_rst_in,    // sync reset, high
  input  wire logic              disable_in,    // readout disabled
  input  wire logic              start_in,      // read accepted pulse
  input  wire logic [BYTE_W-1:0] byte_in,       // value read
  output logic                   pin_out,       // serial_out_pin level
  output logic                   pin_oe_out,    // serial_out_pin enable
  output logic                   busy_out       // shift in progress
);
  import ocr_pkg::*;

  localparam int CNT_W = $clog2(BYTE_W + 1);

  ocr_sh_state_t     state_r, state_nxt;
  logic [BYTE_W-1:0] shreg_r, shreg_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              pin_nxt, oe_nxt;

  // next state; a start while busy is dropped so a later read never tears a readout
  always_comb begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    cnt_nxt   = cnt_r;
    pin_nxt   = 1'b0;
    oe_nxt    = 1'b0;
    case (state_r)
      OCR_SH_IDLE: begin
        if (start_in && !disable_in) begin
          state_nxt = OCR_SH_SHIFT;
          shreg_nxt = byte_in;
          cnt_nxt   = CNT_W'(BYTE_W);
        end
      end
      OCR_SH_SHIFT: begin
        shreg_nxt = {shreg_r[BYTE_W-2:0], 1'b0};
        cnt_nxt   = cnt_r - 1'b1;
        if (cnt_r == CNT_W'(1)) begin
          state_nxt = OCR_SH_IDLE;
        end
      end
      default: state_nxt = OCR_SH_IDLE;
    endcase
    if (disable_in) begin
      // pin held actively low, never released to high impedance
      state_nxt = OCR_SH_IDLE;
      oe_nxt    = 1'b1;
      pin_nxt   = 1'b0;
    end else if (state_nxt == OCR_SH_SHIFT) begin
      // register contents leave on the pin during a read
      oe_nxt    = 1'b1;
      pin_nxt   = shreg_nxt[BYTE_W-1];
    end
  end

  // registers; pin released after reset since readout defaults enabled
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_r    <= OCR_SH_IDLE;
      shreg_r    <= '0;
      cnt_r      <= '0;
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b0;
      busy_out   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      shreg_r    <= shreg_nxt;
      cnt_r      <= cnt_nxt;
      pin_out    <= pin_nxt;
      pin_oe_out <= oe_nxt;
      busy_out   <= (state_nxt == OCR_SH_SHIFT);
    end
  end

endmodule

/* ocr_regs_assertions.sv */
// ocr_regs_assertions: port-level checks of the output configuration register bank
`timescale 1ns/1ps
module ocr_regs_assertions
  import ocr_pkg::*;
#(
  parameter int SAMPLE_W  = 11,  // converter sample width
  parameter int OFS_SHIFT = 8    // offset loop time constant
) (
  input wire logic                 core_clk_in,           // core clock
  input wire logic                 sys_rst_in,            // sync reset
  input wire logic                 hsel_in,               // ahb select
  input wire logic [31:0]          haddr_in,              // ahb address
  input wire logic [1:0]           htrans_in,             // ahb transfer type
  input wire logic                 hwrite_in,             // ahb write
  input wire logic [OCR_BUS_W-1:0] hwdata_in,             // ahb write data
  input wire logic                 hready_in,             // ahb ready
  input wire logic                 hreadyout_out,         // slave ready
  input wire logic [OCR_BUS_W-1:0] hrdata_out,            // read data
  input wire logic                 hresp_out,             // response
  input wire logic                 sample_valid_in,       // sample strobe
  input wire logic [SAMPLE_W-1:0]  sample_in,             // sample
  input wire logic [SAMPLE_W:0]    corrected_out,         // corrected sample
  input wire logic                 serial_out_pin_out,    // pin level
  input wire logic                 serial_out_pin_oe_out, // pin enable
  input wire logic [1:0]           clk_drive_out,         // clock drive
  input wire logic [1:0]           data_drive_out,        // data drive
  input wire logic [1:0]           lvds_current_out,      // current code
  input wire logic                 clk_double_out,        // clock x2
  input wire logic                 data_double_out,       // data x2
  input wire logic [2:0]           data_term_out,         // data termination
  input wire logic [2:0]           clk_term_out,          // clock termination
  input wire logic                 offset_frozen_out      // loop on hold
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // a write taken to one register, ending at the edge where its data stands
  sequence s_wr(logic [7:0] idx);
    hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in == {22'h0, idx, 2'b00} ##1 1'b1;
  endsequence

  // frozen long enough that the estimate used for two results is the same
  sequence s_held;
    offset_frozen_out[*3] ##0 sample_valid_in && $past(sample_valid_in) && $stable(sample_in);
  endsequence

  chk_clk_drive_wr: assert property (s_wr(OCR_IDX_CLK_DRIVE) |=> clk_drive_out == $past(hwdata_in[7:6])) else $error("clock drive mismatch");
  chk_cur_drive_wr: assert property (s_wr(OCR_IDX_CUR_DRIVE) |=> {lvds_current_out, data_drive_out} == $past(hwdata_in[3:0])) else $error("data drive or current mismatch");
  chk_double_map: assert property (s_wr(OCR_IDX_CUR_DRIVE) |=> {clk_double_out, data_double_out} == {$past(hwdata_in[5:4]) inside {2'h1, 2'h2}, $past(hwdata_in[5:4]) == 2'h2}) else $error("doubling mismatch");
  chk_term_wr: assert property (s_wr(OCR_IDX_TERM) |=> {data_term_out, clk_term_out} == $past(hwdata_in[5:0])) else $error("termination mismatch");
  chk_freeze_wr: assert property (s_wr(OCR_IDX_OFS_HOLD) |=> offset_frozen_out == $past(hwdata_in[4])) else $error("freeze bit mismatch");
  chk_freeze_hold: assert property (s_held |=> $stable(corrected_out)) else $error("estimate moved while frozen");
  chk_soft_reset: assert property (s_wr(OCR_IDX_RST_READOUT) ##0 hwdata_in[1] |=> {clk_drive_out, data_drive_out, lvds_current_out, data_term_out, clk_term_out, offset_frozen_out} == '0) else $error("soft reset left a field set");
  chk_readout_off: assert property (s_wr(OCR_IDX_RST_READOUT) ##0 hwdata_in[1:0] == 2'b01 |=> ##1 serial_out_pin_oe_out && !serial_out_pin_out) else $error("pin not driven low");
  chk_bus_okay: assert property (hreadyout_out && !hresp_out && hrdata_out[31:8] == 24'h0) else $error("bus answer not okay");
endmodule

bind ocr_regs ocr_regs_assertions #(.SAMPLE_W(SAMPLE_W), .OFS_SHIFT(OFS_SHIFT)) u_ocr_regs_assertions (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out), .hresp_out(hresp_out),
  .sample_valid_in(sample_valid_in), .sample_in(sample_in), .corrected_out(corrected_out),
  .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out),
  .clk_drive_out(clk_drive_out), .data_drive_out(data_drive_out),
  .lvds_current_out(lvds_current_out), .clk_double_out(clk_double_out),
  .data_double_out(data_double_out), .data_term_out(data_term_out),
  .clk_term_out(clk_term_out), .offset_frozen_out(offset_frozen_out));

/* ocr_host_model.sv */
// ocr_host_model: configuration host issuing single ahb-lite word transfers
`timescale 1ns/1ps
module ocr_host_model (
  input  wire logic        core_clk_in, // core clock
  input  wire logic        hready_in,   // bus ready
  input  wire logic [31:0] hrdata_in,   // read data
  output logic             hsel_out,    // slave select
  output logic [31:0]      haddr_out,   // byte address
  output logic [1:0]       htrans_out,  // transfer type
  output logic             hwrite_out,  // write
  output logic [31:0]      hwdata_out,  // write data
  output logic             tmo_out      // a wait ran out
);
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hwdata_out = 32'h0;
    tmo_out    = 1'b0;
  end

  // one whole register byte per transfer, so several fields go together
  // fixed-zero bits are set only where a caller checks they are dropped
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                      output logic [31:0] r);
    int n;
    hsel_out   <= 1'b1;
    haddr_out  <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    n = 0;
    do begin @(posedge core_clk_in); n++; end while (hready_in !== 1'b1 && n < 64);
    if (n >= 64) tmo_out = 1'b1;
    hsel_out   <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= {24'h0, d};
    n = 0;
    do begin @(posedge core_clk_in); n++; end while (hready_in !== 1'b1 && n < 64);
    if (n >= 64) tmo_out = 1'b1;
    r = hrdata_in;
  endtask
endmodule

/* tb_ocr_regs.sv */
// tb_ocr_regs: directed register and pad output tests of the output config bank
`timescale 1ns/1ps
module tb_ocr_regs;
  import ocr_pkg::*;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, sample_valid_in = 1'b0;
  logic hsel_in, hwrite_in, hreadyout_out, hresp_out, tmo;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0] htrans_in, clk_drive_out, data_drive_out, lvds_current_out;
  logic [10:0] sample_in = 11'h028;
  logic [11:0] corrected_out, c1;
  logic pin, pin_oe, vld, clk_double_out, data_double_out, offset_frozen_out;
  logic [2:0] data_term_out, clk_term_out;
  logic [7:0] sh = 8'h00;
  logic [7:0] idx_l [4] = '{OCR_IDX_CLK_DRIVE, OCR_IDX_CUR_DRIVE, OCR_IDX_TERM, OCR_IDX_OFS_HOLD};
  logic [7:0] msk_l [4] = '{OCR_MASK_CLK_DRIVE, OCR_MASK_CUR_DRIVE, OCR_MASK_TERM, OCR_MASK_OFS_HOLD};
  int err_count = 0, comparisons = 0;

  always #2 core_clk_in = ~core_clk_in;

  ocr_host_model u_ocr_host_model (.core_clk_in(core_clk_in), .hready_in(hreadyout_out),
    .hrdata_in(hrdata_out), .hsel_out(hsel_in), .haddr_out(haddr_in), .htrans_out(htrans_in),
    .hwrite_out(hwrite_in), .hwdata_out(hwdata_in), .tmo_out(tmo));

  // short loop constant keeps the estimate moving within a few samples
  ocr_regs #(.SAMPLE_W(11), .OFS_SHIFT(2)) u_ocr_regs (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out), .hresp_out(hresp_out),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in), .corrected_out(corrected_out),
    .corrected_vld_out(vld), .serial_out_pin_out(pin), .serial_out_pin_oe_out(pin_oe),
    .clk_drive_out(clk_drive_out), .data_drive_out(data_drive_out),
    .lvds_current_out(lvds_current_out), .clk_double_out(clk_double_out),
    .data_double_out(data_double_out), .data_term_out(data_term_out),
    .clk_term_out(clk_term_out), .offset_frozen_out(offset_frozen_out));

  // serial pin capture, one bit per edge while the pin is driven
  always @(posedge core_clk_in) begin
    if (pin_oe === 1'b1) sh <= {sh[6:0], pin};
  end

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits past the edge so outputs updated there have settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    u_ocr_host_model.xfer(1'b1, {22'h0, i, 2'b00}, d, r);
    #1;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] r;
    u_ocr_host_model.xfer(1'b0, {22'h0, i, 2'b00}, 8'h00, r);
    chk(r, {24'h0, e});
    #1;
  endtask

  // a stuck handshake or a hung run ends in the closing report
  always @(posedge core_clk_in) begin
    if (tmo === 1'b1) begin err_count++; end_of_test(); end
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge core_clk_in);
    sys_rst_in      <= 1'b0;
    sample_valid_in <= 1'b1;
    tick(1);
    // freeze early, while the estimate is still moving
    wr(OCR_IDX_OFS_HOLD, 8'h10);
    chk(offset_frozen_out, 1);
    chk(vld, 1);
    tick(2);
    c1 = corrected_out;
    chk(c1, 12'h011);
    tick(4);
    chk(corrected_out, c1);
    wr(OCR_IDX_OFS_HOLD, 8'h00);
    tick(4);
    chk(corrected_out, 12'h007);
    rd(OCR_IDX_RST_READOUT, 8'h00);
    // fixed-zero bits written as one are dropped, unmapped index ignored
    for (int i = 0; i < 4; i++) begin
      rd(idx_l[i], 8'h00);
      wr(idx_l[i], 8'hff);
      rd(idx_l[i], msk_l[i]);
    end
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h00);
    // every drive, current and doubling code, fields set in one write
    for (int c = 0; c < 4; c++) begin
      wr(OCR_IDX_CLK_DRIVE, {c[1:0], 6'h00});
      chk(clk_drive_out, c);
      wr(OCR_IDX_CUR_DRIVE, {2'h0, c[1:0], c[1:0], c[1:0]});
      chk({data_drive_out, lvds_current_out}, {c[1:0], c[1:0]});
      chk({clk_double_out, data_double_out}, {c == 1 || c == 2, c == 2});
    end
    for (int t = 0; t < 8; t++) begin
      wr(OCR_IDX_TERM, {2'h0, t[2:0], ~t[2:0]});
      chk({data_term_out, clk_term_out}, {t[2:0], ~t[2:0]});
    end
    // serial readout shifts the read byte out msb first
    wr(OCR_IDX_CUR_DRIVE, 8'h2d);
    tick(10);
    rd(OCR_IDX_CUR_DRIVE, 8'h2d);
    rd(OCR_IDX_STATUS, 8'h01);
    tick(10);
    chk(sh, 8'h2d);
    chk(pin_oe, 0);
    // readout off: pin held low even across a read
    wr(OCR_IDX_RST_READOUT, 8'h01);
    tick(2);
    chk({pin_oe, pin}, 2'b10);
    rd(OCR_IDX_RST_READOUT, 8'h01);
    chk({pin_oe, pin}, 2'b10);
    // soft reset wins over the readout bit of the same write
    wr(OCR_IDX_CLK_DRIVE, 8'hc0);
    wr(OCR_IDX_RST_READOUT, 8'h03);
    chk({clk_drive_out, data_drive_out, lvds_current_out, data_term_out}, 0);
    for (int i = 0; i < 4; i++) rd(idx_l[i], 8'h00);
    rd(OCR_IDX_RST_READOUT, 8'h00);
    chk(pin_oe, 0);
    end_of_test();
  end
endmodule
